// file: rtl/amx_params.svh
`ifndef AMX_PARAMS_SVH
`define AMX_PARAMS_SVH
// core clock rate, used to turn times into cycle counts
`define AMX_CLK_MHZ 50
// whole channel change, break interval included
`define AMX_SWITCH_NS 100
`define AMX_BREAK_NS 40
// least time: round up
`define AMX_BREAK_CYC ((`AMX_BREAK_NS * `AMX_CLK_MHZ + 999) / 1000)
// longest time: round down
`define AMX_MAKE_CYC (((`AMX_SWITCH_NS - `AMX_BREAK_NS) * `AMX_CLK_MHZ) / 1000)
`define AMX_SHIFT_BITS 8
`define AMX_SEL_BITS 4
`define AMX_CHANNELS 16
`define AMX_RESET_CHAN 4'h0
`define AMX_CNT_W 4
// host side: clk cycles per half link clock period, parallel select low time
`define AMX_SCLK_HALF 4
`define AMX_PAR_HOLD 6
`endif

// file: rtl/amx_pkg.sv
package amx_pkg;
  typedef logic [3:0] amx_chan_t;
  typedef logic [7:0] amx_byte_t;
  typedef logic [3:0] amx_cnt_t;
  typedef enum logic [3:0] {
    AMX_SW_HIZ = 4'b0001,
    AMX_SW_ON = 4'b0010,
    AMX_SW_BREAK = 4'b0100,
    AMX_SW_MAKE = 4'b1000
  } amx_sw_state_t;
  typedef enum logic [4:0] {
    AMX_H_RESET = 5'b00001,
    AMX_H_INIT = 5'b00010,
    AMX_H_IDLE = 5'b00100,
    AMX_H_SER = 5'b01000,
    AMX_H_PAR = 5'b10000
  } amx_host_state_t;
endpackage

// file: rtl/amx_link_if.sv
`timescale 1ns/1ps
interface amx_link_if;
  logic sclk;
  logic mosi;
  logic miso;
  logic [3:0] addr;
  logic ss_n_o;
  logic ss_oe;
  logic cs_n_o;
  logic cs_oe;
  logic rst_n_o;
  logic rst_oe;
  logic ss_n;
  logic cs_n;
  logic mux_rst_n;
  // =========================================
  // pull-ups: an undriven select or reset reads inactive
  assign ss_n = ss_oe ? ss_n_o : 1'b1;
  assign cs_n = cs_oe ? cs_n_o : 1'b1;
  assign mux_rst_n = rst_oe ? rst_n_o : 1'b1;
  modport dev (input sclk, input mosi, input ss_n, input cs_n, input mux_rst_n,
    input addr, output miso);
  modport host (output sclk, output mosi, output ss_n_o, output ss_oe,
    output cs_n_o, output cs_oe, output rst_n_o, output rst_oe, output addr,
    input miso);
endinterface

// file: rtl/amx_dev.sv
`timescale 1ns/1ps
`include "amx_params.svh"
module amx_dev (
  input wire logic clk,
  input wire logic rst_n,
  amx_link_if.dev link,
  input wire logic serial_mode,
  output logic [15:0] chan_en,
  output amx_pkg::amx_chan_t chan_sel,
  output logic hiz,
  output logic switching,
  output logic par_init_done
);
  import amx_pkg::*;

  // =========================================
  // link clock domain: shift path
  amx_byte_t shift_reg;
  logic miso_reg;

  always_ff @(posedge link.sclk or negedge link.mux_rst_n)
  begin
    if (!link.mux_rst_n)
    begin
      shift_reg <= '0;
    end
    else if (!link.ss_n)
    begin
      // first rising edge takes the top bit, so msb lands in bit 7
      shift_reg <= {shift_reg[6:0], link.mosi};
    end
  end

  // falling edges only, so bit 7 already sits on the pin before the first rise
  always_ff @(negedge link.sclk or negedge link.mux_rst_n)
  begin
    if (!link.mux_rst_n)
    begin
      miso_reg <= 1'b0;
    end
    else if (!link.ss_n)
    begin
      miso_reg <= shift_reg[7];
    end
  end

  assign link.miso = miso_reg;

  // =========================================
  // reset pin into the core domain
  // asserts at once, releases two edges later to avoid a ragged release
  logic mrst_q1;
  logic mrst_q2;

  always_ff @(posedge clk or negedge link.mux_rst_n)
  begin
    if (!link.mux_rst_n)
    begin
      mrst_q1 <= 1'b0;
      mrst_q2 <= 1'b0;
    end
    else
    begin
      mrst_q1 <= 1'b1;
      mrst_q2 <= mrst_q1;
    end
  end

  // =========================================
  // pin synchronisers
  logic ss_s1;
  logic ss_s2;
  logic ss_s3;
  logic cs_s1;
  logic cs_s2;
  amx_chan_t a_s1;
  amx_chan_t a_s2;
  amx_chan_t a_prev;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      ss_s3 <= 1'b1;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      a_s1 <= '0;
      a_s2 <= '0;
      a_prev <= '0;
    end
    else
    begin
      ss_s1 <= link.ss_n;
      ss_s2 <= ss_s1;
      ss_s3 <= ss_s2;
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      a_s1 <= link.addr;
      a_s2 <= a_s1;
      a_prev <= a_s2;
    end
  end

  // shift_reg is quiet once SS is high, so reading it here is safe
  logic ss_rise;
  logic par_take;
  assign ss_rise = ss_s2 && !ss_s3;
  // two equal samples 20ns apart ride out the line-to-line skew
  assign par_take = !cs_s2 && (a_s2 == a_prev);

  // =========================================
  // address decoding register
  amx_chan_t target_reg;

  always_ff @(posedge clk or negedge mrst_q2)
  begin
    if (!mrst_q2)
    begin
      target_reg <= `AMX_RESET_CHAN;
    end
    else if (!rst_n)
    begin
      target_reg <= `AMX_RESET_CHAN;
    end
    else if (serial_mode && ss_rise)
    begin
      // bit count is not checked: whatever sits in the low bits wins
      target_reg <= shift_reg[3:0];
    end
    else if (!serial_mode && par_take)
    begin
      target_reg <= a_s2;
    end
  end

  // status only: all sixteen codes taken in parallel mode since reset
  logic [15:0] seen_reg;

  always_ff @(posedge clk or negedge mrst_q2)
  begin
    if (!mrst_q2)
    begin
      seen_reg <= '0;
    end
    else if (!rst_n)
    begin
      seen_reg <= '0;
    end
    else if (!serial_mode && par_take)
    begin
      seen_reg[a_s2] <= 1'b1;
    end
  end

  assign par_init_done = &seen_reg;

  // =========================================
  // break-before-make sequencer
  amx_sw_state_t state_reg;
  amx_sw_state_t state_next;
  amx_cnt_t cnt_reg;
  amx_cnt_t cnt_next;
  amx_chan_t cur_reg;
  amx_chan_t cur_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cur_next = cur_reg;
    case (state_reg)
      AMX_SW_HIZ:
      begin
        state_next = AMX_SW_ON;
      end
      AMX_SW_ON:
      begin
        if (target_reg != cur_reg)
        begin
          state_next = AMX_SW_BREAK;
          cnt_next = amx_cnt_t'(`AMX_BREAK_CYC - 1);
        end
      end
      AMX_SW_BREAK:
      begin
        if (cnt_reg == '0)
        begin
          state_next = AMX_SW_MAKE;
          cur_next = target_reg;
          cnt_next = amx_cnt_t'(`AMX_MAKE_CYC - 1);
        end
        else
        begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      AMX_SW_MAKE:
      begin
        if (cnt_reg == '0)
        begin
          state_next = AMX_SW_ON;
        end
        else
        begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default:
      begin
        state_next = AMX_SW_HIZ;
      end
    endcase
  end

  always_ff @(posedge clk or negedge mrst_q2)
  begin
    if (!mrst_q2)
    begin
      state_reg <= AMX_SW_HIZ;
      cnt_reg <= '0;
      cur_reg <= `AMX_RESET_CHAN;
    end
    else if (!rst_n)
    begin
      state_reg <= AMX_SW_HIZ;
      cnt_reg <= '0;
      cur_reg <= `AMX_RESET_CHAN;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cur_reg <= cur_next;
    end
  end

  // =========================================
  // switch enables, registered
  logic [15:0] dec_next;
  logic [15:0] chan_en_reg;
  logic hiz_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `AMX_CHANNELS; gi = gi + 1)
    begin : g_dec
      assign dec_next[gi] = (state_next == AMX_SW_ON) && (cur_next == amx_chan_t'(gi));
    end
  endgenerate

  always_ff @(posedge clk or negedge mrst_q2)
  begin
    if (!mrst_q2)
    begin
      chan_en_reg <= '0;
      hiz_reg <= 1'b1;
    end
    else if (!rst_n)
    begin
      chan_en_reg <= '0;
      hiz_reg <= 1'b1;
    end
    else
    begin
      chan_en_reg <= dec_next;
      hiz_reg <= (state_next == AMX_SW_HIZ);
    end
  end

  assign chan_en = chan_en_reg;
  assign chan_sel = cur_reg;
  assign hiz = hiz_reg;
  assign switching = (state_reg == AMX_SW_BREAK) || (state_reg == AMX_SW_MAKE);
endmodule

// file: rtl/amx_host.sv
`timescale 1ns/1ps
`include "amx_params.svh"
module amx_host (
  input wire logic clk,
  input wire logic rst_n,
  amx_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_serial,
  input wire amx_pkg::amx_byte_t cmd_data,
  input wire logic mux_reset_req,
  output logic rsp_valid,
  output amx_pkg::amx_byte_t rsp_data,
  output logic init_done
);
  import amx_pkg::*;

  amx_host_state_t state_reg;
  amx_cnt_t div_reg;
  amx_cnt_t bit_reg;
  amx_cnt_t code_reg;
  amx_byte_t sh_reg;
  amx_byte_t rx_reg;
  logic sclk_reg;
  logic ss_n_reg;
  logic cs_n_reg;
  logic mrst_n_reg;
  logic oe_reg;
  logic rsp_reg;
  logic done_reg;
  amx_chan_t addr_reg;
  logic miso_s1;
  logic miso_s2;
  logic half_end;

  // =========================================
  // device data back into the core domain
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end
    else
    begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
    end
  end

  assign half_end = (div_reg == amx_cnt_t'(`AMX_SCLK_HALF - 1));

  // =========================================
  // sequencer: reset, address walk, serial frame, parallel write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= AMX_H_RESET;
      mrst_n_reg <= 1'b0;
      oe_reg <= 1'b0;
      sclk_reg <= 1'b0;
      ss_n_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      addr_reg <= '0;
      div_reg <= '0;
      bit_reg <= '0;
      code_reg <= '0;
      sh_reg <= '0;
      rx_reg <= '0;
      rsp_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      rsp_reg <= 1'b0;
      oe_reg <= 1'b1;
      case (state_reg)
        AMX_H_RESET:
        begin
          mrst_n_reg <= mux_reset_req ? 1'b0 : 1'b1;
          if (!mux_reset_req)
          begin
            state_reg <= AMX_H_INIT;
            code_reg <= '0;
            div_reg <= '0;
            done_reg <= 1'b0;
          end
        end
        AMX_H_INIT, AMX_H_PAR:
        begin
          // address set at the same edge as select low, all lines together
          div_reg <= div_reg + 4'h1;
          if (div_reg == '0)
          begin
            addr_reg <= (state_reg == AMX_H_INIT) ? code_reg : sh_reg[3:0];
            cs_n_reg <= 1'b0;
          end
          else if (div_reg == amx_cnt_t'(`AMX_PAR_HOLD))
          begin
            cs_n_reg <= 1'b1;
            div_reg <= '0;
            code_reg <= code_reg + 4'h1;
            if (state_reg == AMX_H_PAR || code_reg == 4'hf)
            begin
              state_reg <= AMX_H_IDLE;
              done_reg <= 1'b1;
            end
          end
        end
        AMX_H_IDLE:
        begin
          div_reg <= '0;
          bit_reg <= '0;
          if (mux_reset_req)
          begin
            state_reg <= AMX_H_RESET;
            mrst_n_reg <= 1'b0;
          end
          else if (cmd_valid)
          begin
            sh_reg <= cmd_data;
            state_reg <= cmd_serial ? AMX_H_SER : AMX_H_PAR;
            ss_n_reg <= !cmd_serial;
          end
        end
        AMX_H_SER:
        begin
          div_reg <= half_end ? 4'h0 : div_reg + 4'h1;
          if (half_end)
          begin
            if (sclk_reg)
            begin
              sclk_reg <= 1'b0;
              sh_reg <= {sh_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
            end
            else if (bit_reg < amx_cnt_t'(`AMX_SHIFT_BITS))
            begin
              sclk_reg <= 1'b1;
              rx_reg <= {rx_reg[6:0], miso_s2};
            end
            else if (bit_reg == amx_cnt_t'(`AMX_SHIFT_BITS))
            begin
              ss_n_reg <= 1'b1;
              bit_reg <= amx_cnt_t'(`AMX_SHIFT_BITS + 1);
            end
            else
            begin
              state_reg <= AMX_H_IDLE;
              rsp_reg <= 1'b1;
            end
          end
        end
        default:
        begin
          state_reg <= AMX_H_RESET;
        end
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.mosi = sh_reg[7];
  assign link.ss_n_o = ss_n_reg;
  assign link.ss_oe = oe_reg;
  assign link.cs_n_o = cs_n_reg;
  assign link.cs_oe = oe_reg;
  assign link.rst_n_o = mrst_n_reg;
  assign link.rst_oe = 1'b1;
  assign link.addr = addr_reg;
  assign cmd_ready = (state_reg == AMX_H_IDLE) && !mux_reset_req;
  assign rsp_valid = rsp_reg;
  assign rsp_data = rx_reg;
  assign init_done = done_reg;
endmodule

// file: test/amx_link_asserts.sv
`timescale 1ns/1ps
module amx_link_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic miso,
  input wire logic ss_n,
  input wire logic cs_n,
  input wire logic mux_rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] chan_en,
  input wire logic hiz
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // switch path
  AST_ONE_HOT: assert property ($onehot0(chan_en))
    else $error("more than one channel enabled");
  AST_BREAK_FIRST: assert property ((chan_en != 0 && $past(chan_en) != 0)
    |-> chan_en == $past(chan_en)) else $error("channel moved without a break");
  AST_MAKE_TIME: assert property ((chan_en == 0 && $past(chan_en) != 0 && mux_rst_n)
    |-> ##[1:5] chan_en != 0) else $error("new channel not made in time");
  AST_HIZ_RESET: assert property (!mux_rst_n |-> hiz && chan_en == 0)
    else $error("analog pins not isolated in reset");
  AST_RESET_CHAN0: assert property ($rose(mux_rst_n) |-> ##[2:5]
    (chan_en == 16'h0001 && !hiz)) else $error("channel 0 not driven after reset");
  // ==========================================
  // link wires
  AST_MISO_FALL: assert property ((mux_rst_n && $past(mux_rst_n) && $changed(miso))
    |-> $fell(sclk) && !ss_n) else $error("miso moved off a falling link edge");
  AST_SCLK_IDLE: assert property (ss_n |-> !sclk)
    else $error("link clock active outside frame");
  AST_ADDR_STABLE: assert property ((!cs_n && $past(!cs_n)) |-> $stable(addr))
    else $error("address moved while select low");
  COV_FRAME: cover property ($fell(ss_n));
  COV_PAR: cover property ($fell(cs_n));
  COV_MUX_RST: cover property ($rose(mux_rst_n));
endmodule

// file: test/analog_mux_channel_select_tb.sv
`timescale 1ns/1ps
module analog_mux_channel_select_tb;
  import amx_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic serial_mode = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_serial = 1'b0;
  amx_byte_t cmd_data = 8'h00;
  logic mux_reset_req = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  amx_byte_t rsp_data;
  logic init_done;
  logic [15:0] chan_en;
  amx_chan_t chan_sel;
  logic hiz;
  logic switching;
  logic par_init_done;
  int bad_count = 0;
  int total_checks = 0;
  amx_link_if link ();
  amx_host i_amx_host (.clk(clk), .rst_n(rst_n), .link(link.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_serial(cmd_serial), .cmd_data(cmd_data),
    .mux_reset_req(mux_reset_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .init_done(init_done));
  amx_dev i_amx_dev (.clk(clk), .rst_n(rst_n), .link(link.dev), .serial_mode(serial_mode),
    .chan_en(chan_en), .chan_sel(chan_sel), .hiz(hiz), .switching(switching),
    .par_init_done(par_init_done));
  amx_link_asserts i_amx_link_asserts (.clk(clk), .rst_n(rst_n), .sclk(link.sclk),
    .miso(link.miso), .ss_n(link.ss_n), .cs_n(link.cs_n), .mux_rst_n(link.mux_rst_n),
    .addr(link.addr), .chan_en(chan_en), .hiz(hiz));
  // ==========================================
  // clock, verdict, watchdog
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    // whole run is well under 20000 core clock cycles
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  // ==========================================
  // access tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic send(input logic ser, input amx_byte_t data);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_serial <= ser;
    cmd_data <= data;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clk);
      if (cmd_ready === 1'b1)
        break;
    end
    chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
    cmd_valid <= 1'b0;
  endtask
  task automatic expect_chan(input amx_chan_t ch);
    repeat (20) @(posedge clk);
    chk("chan_sel", {12'h000, ch}, {12'h000, chan_sel});
    chk("chan_en", 16'h0001 << ch, chan_en);
    chk("switching", 16'h0000, {15'h0000, switching});
  endtask
  task automatic frame(input amx_byte_t data, input amx_byte_t prev);
    send(1'b1, data);
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if (rsp_valid === 1'b1)
        break;
    end
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    chk("rsp_data", {8'h00, prev}, {8'h00, rsp_data});
    expect_chan(data[3:0]);
  endtask
  // ==========================================
  // tests
  initial
  begin
    repeat (5) @(posedge clk);
    // select enables are off in reset, so pull-ups decide them; the host drives the reset line low
    chk("ss_n", 16'h0001, {15'h0000, link.ss_n});
    chk("cs_n", 16'h0001, {15'h0000, link.cs_n});
    chk("mux_rst_n", 16'h0000, {15'h0000, link.mux_rst_n});
    rst_n <= 1'b1;
    for (int i = 0; i < 1000; i++)
    begin
      @(posedge clk);
      if (init_done === 1'b1)
        break;
    end
    chk("init_done", 16'h0001, {15'h0000, init_done});
    // host walks every code at start-up and ends on the top channel
    expect_chan(4'hf);
    chk("par_init_done", 16'h0001, {15'h0000, par_init_done});
    $display("test init done");
    send(1'b0, 8'h05);
    // mid-way through the break/make window of the new address
    repeat (8) @(posedge clk);
    chk("switching", 16'h0001, {15'h0000, switching});
    expect_chan(4'h5);
    send(1'b0, 8'h0a);
    expect_chan(4'ha);
    $display("test parallel done");
    serial_mode <= 1'b1;
    // shift register starts cleared by the pin reset
    frame(8'h09, 8'h00);
    frame(8'hf6, 8'h09);
    frame(8'h5a, 8'hf6);
    $display("test serial done");
    @(posedge clk);
    mux_reset_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("hiz", 16'h0001, {15'h0000, hiz});
    chk("chan_en", 16'h0000, chan_en);
    mux_reset_req <= 1'b0;
    expect_chan(4'h0);
    chk("hiz", 16'h0000, {15'h0000, hiz});
    frame(8'h03, 8'h00);
    $display("test reset done");
    stop_test();
  end
endmodule
